/* mqf_host_model.sv */
/*
  Host-side partner of the port controller: drives the serial
  configuration chain and resolves the three-state data and almost-empty pins.
  Assumes one clock shared with the device; inputs change at falling edges.
*/
module mqf_host_model
  import mqf_pkg::*;
(
  // clock
  input  wire logic              clk,
  // serial chain source
  output logic                   serialLoadEnableN,
  output logic                   serialIn,
  input  wire logic              serialEnableOutN,
  // three-state pins as seen on the board
  input  wire logic [DATA_W-1:0] dataOut,
  input  wire logic              dataOe,
  input  wire logic              almostEmptyN,
  input  wire logic              almostEmptyOe,
  output logic [DATA_W-1:0]      qBus,
  output logic                   aeWire
);
  import mqf_pkg::*;
  logic [DATA_W-1:0] qLast = '0;
  logic              aeLast = 1'b0;

  initial begin
    serialLoadEnableN = 1'b1;
    serialIn = 1'b0;
  end

  // released pins show a changing pattern, never the last value
  always_comb qBus = dataOe ? dataOut : ~qLast;
  always_comb aeWire = almostEmptyOe ? almostEmptyN : ~aeLast;
  always @(posedge clk) begin
    qLast <= qBus;
    aeLast <= aeWire;
  end

  // msb first, then enable high for one clock and then held low as the end of a one-device chain
  task automatic loadCfg(input logic [CFG_BITS-1:0] cfg);
    for (int i = CFG_BITS - 1; i >= 0; i--) begin
      @(negedge clk);
      serialLoadEnableN = 1'b0;
      serialIn = cfg[i];
    end
    @(negedge clk);
    serialLoadEnableN = 1'b1;
    serialIn = 1'b1;
    @(negedge clk);
    serialLoadEnableN = 1'b0;
  endtask

  // no port traffic before the chain end reports done
  task automatic waitChain();
    for (int n = 0; n < 8 && serialEnableOutN !== 1'b0; n++) @(negedge clk);
  endtask
endmodule

/* mqf_pkg.sv */
/*
  Shared constants for the multi-queue port controller: data and queue
  geometry, configuration field layout, default flag offsets and the
  switch latencies of both ports.
  Assumes one 10 MHz clock drives both the write and the read port.
*/
package mqf_pkg;

  // geometry
  localparam int DATA_W    = 36;
  localparam int QUEUE_CNT = 4;
  localparam int QSEL_W    = 2;
  localparam int DEPTH     = 8;
  localparam int PTR_W     = 3;
  localparam int CNT_W     = 4;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 4'h8;

  // serial configuration word: almost-empty offset in the upper field
  localparam int OFS_W     = 4;
  localparam int CFG_BITS  = 8;
  localparam int CFG_CNT_W = 4;
  localparam int AE_OFS_LSB = 4;
  localparam int AF_OFS_LSB = 0;
  localparam logic [CFG_CNT_W-1:0] CFG_LAST_BIT = 4'h7;

  // default offsets when not serially loaded, chosen by the flag default pin
  localparam logic [OFS_W-1:0] AE_DEFAULT_0 = 4'h2;
  localparam logic [OFS_W-1:0] AE_DEFAULT_1 = 4'h4;
  localparam logic [OFS_W-1:0] AF_DEFAULT_0 = 4'h2;
  localparam logic [OFS_W-1:0] AF_DEFAULT_1 = 4'h4;

  // straps pass two flops, then are captured
  localparam logic [1:0] STRAP_CAPTURE_CYCLES = 2'h2;

  // read queue switch takes four clocks, counted down to one
  localparam logic [2:0] RD_SWITCH_CYCLES = 3'h4;
  localparam logic [2:0] RD_SWITCH_LOAD   = RD_SWITCH_CYCLES - 3'h1;

  // almost-full flag follows a write queue switch after three clocks
  localparam logic [1:0] AF_SWITCH_LAT  = 2'h3;
  localparam logic [1:0] AF_SWITCH_HOLD = AF_SWITCH_LAT - 2'h1;

  typedef enum logic [1:0] {
    CFG_STRAP,
    CFG_LOAD,
    CFG_DONE
  } mqf_cfg_state_t;

endpackage

/* mqf_port_ctrl.sv */
/*
  Write-port and read-port control of a multi-queue flow-control memory
  in first-word-fall-through mode, with full, almost-full, almost-empty and
  output-ready flags, read queue switching, queue marking and expansion
  hand-over of the output pins.
  Assumes host write and read ports run on clk; pins driven here as
  output plus enable are resolved to a wire outside.
*/
// Summary of operation
// - loaded device passes chain enable and data
// - serial mode from straps low during reset
// - no serial loads after chain end low
// - first word falls through one clock later
// - last free slot drops full, writes ignored
// - read switch takes four clocks, old queue
// - after switch new word shown regardless enable
// - read to empty raises output ready flag
// - output ready stays low while words remain
// - reads disabled hold output word
// - no fall-through until new queue word
// - at most one queue marked
// - marking only during a queue switch
// - output enable acts asynchronously
// - almost-full follows write switch after three
// - write to boundary lowers almost-full two later
// - read off boundary releases almost-full one later
// - read at boundary lowers almost-empty two later
// - unselected device floats data and almost-empty
module mqf_port_ctrl
  import mqf_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // setup straps
  input  wire logic                 programmingModeSelect,
  input  wire logic                 offsetSelectLow,
  input  wire logic                 offsetSelectHigh,
  input  wire logic                 flagDefaultSelect,
  // serial chain
  input  wire logic                 serialLoadEnableN,
  input  wire logic                 serialIn,
  output logic                      serialEnableOutN,
  output logic                      serialOut,
  output logic                      configDone,
  // write port
  input  wire logic                 writeSelectStrobe,
  input  wire logic [QSEL_W-1:0]    writeQueueSelectBus,
  input  wire logic                 writeChipSelect,
  input  wire logic                 writeEnableN,
  input  wire logic [DATA_W-1:0]    writeData,
  output logic                      queueFullN,
  output logic                      almostFullN,
  output logic                      almostFullOe,
  // read port
  input  wire logic                 readSelectStrobe,
  input  wire logic [QSEL_W-1:0]    readQueueSelectBus,
  input  wire logic                 readChipSelect,
  input  wire logic                 readMarkRequest,
  input  wire logic                 readEnableN,
  input  wire logic                 outputEnableN,
  output logic [DATA_W-1:0]         dataOut,
  output logic                      dataOe,
  output logic                      outputReadyN,
  output logic                      almostEmptyN,
  output logic                      almostEmptyOe,
  output logic                      markValid,
  output logic [QSEL_W-1:0]         markedQueue
);
  import mqf_pkg::*;

  typedef struct packed {
    logic [QSEL_W-1:0]                  wq;
    logic                               wrOwned;
    logic                               fullN;
    logic                               afN;
    logic                               afPrev;
    logic [1:0]                         afHold;
    logic [QSEL_W-1:0]                  rq;
    logic [QSEL_W-1:0]                  rqPend;
    logic                               rdOwned;
    logic                               rdOwnedPend;
    logic [2:0]                         rdSw;
    logic                               forceLoad;
    logic                               outValid;
    logic [DATA_W-1:0]                  dataOut;
    logic                               aeN;
    logic                               aePrev;
    logic                               markValid;
    logic [QSEL_W-1:0]                  markQ;
    logic [QUEUE_CNT-1:0][PTR_W-1:0]    wrPtr;
    logic [QUEUE_CNT-1:0][PTR_W-1:0]    rdPtr;
    logic [QUEUE_CNT-1:0][CNT_W-1:0]    cnt;
  } mqf_port_reg_t;

  mqf_port_reg_t     s_reg;
  mqf_port_reg_t     s_next;
  logic [DATA_W-1:0] mem [QUEUE_CNT*DEPTH];
  logic [DATA_W-1:0] memRd;
  logic [OFS_W-1:0]  aeOfs;
  logic [OFS_W-1:0]  afOfs;
  logic              wrAccept;
  logic              wantPop;
  logic              pop;
  logic              rdStrobe;
  logic              wrStrobe;
  logic              switchDone;

  function automatic logic almostFull(input logic [CNT_W-1:0] c, input logic [OFS_W-1:0] o);
    return c >= (DEPTH_CNT - o);
  endfunction

  function automatic logic almostEmpty(input logic [CNT_W-1:0] c, input logic [OFS_W-1:0] o);
    return c <= o;
  endfunction

  mqf_serial_cfg u_cfg (
    .clk                   (clk),
    .resetn                (resetn),
    .programmingModeSelect (programmingModeSelect),
    .offsetSelectLow       (offsetSelectLow),
    .offsetSelectHigh      (offsetSelectHigh),
    .flagDefaultSelect     (flagDefaultSelect),
    .serialLoadEnableN     (serialLoadEnableN),
    .serialIn              (serialIn),
    .serialEnableOutN      (serialEnableOutN),
    .serialOut             (serialOut),
    .configDone            (configDone),
    .almostEmptyOffset     (aeOfs),
    .almostFullOffset      (afOfs)
  );

  // port activity only once this device is configured
  assign wrStrobe   = configDone && writeSelectStrobe;
  assign rdStrobe   = configDone && readSelectStrobe;
  assign switchDone = (s_reg.rdSw == 3'h1) && !rdStrobe;

  // a full queue swallows no write
  assign wrAccept = configDone && s_reg.wrOwned && !writeEnableN
                    && (s_reg.cnt[s_reg.wq] != DEPTH_CNT);

  // a first word lands in memory, then falls through one clock later
  assign memRd  = mem[{s_reg.rq, s_reg.rdPtr[s_reg.rq]}];

  // fall-through load: output empty, read enabled, or forced after a switch
  assign wantPop = configDone && s_reg.rdOwned
                   && (s_reg.forceLoad || !s_reg.outValid || !readEnableN);
  assign pop     = wantPop && (s_reg.cnt[s_reg.rq] != '0);

  always_comb begin
    logic inc;
    logic dec;
    inc    = 1'b0;
    dec    = 1'b0;
    s_next = s_reg;

    // write queue selection
    if (wrStrobe) begin
      s_next.wq      = writeQueueSelectBus;
      s_next.wrOwned = writeChipSelect;
      s_next.afHold  = AF_SWITCH_HOLD;
    end else if (s_reg.afHold != 2'h0) begin
      s_next.afHold = s_reg.afHold - 2'h1;
    end

    // read queue selection; reads keep using the old queue meanwhile
    s_next.forceLoad = switchDone;
    if (rdStrobe) begin
      s_next.rqPend      = readQueueSelectBus;
      s_next.rdOwnedPend = readChipSelect;
      s_next.rdSw        = RD_SWITCH_LOAD;
      if (readMarkRequest) begin
        s_next.markValid = 1'b1;
        s_next.markQ     = readQueueSelectBus;
      end
    end else if (s_reg.rdSw != 3'h0) begin
      s_next.rdSw = s_reg.rdSw - 3'h1;
      if (switchDone) begin
        s_next.rq      = s_reg.rqPend;
        s_next.rdOwned = s_reg.rdOwnedPend;
      end
    end

    // output register
    if (pop) begin
      s_next.dataOut  = memRd;
      s_next.outValid = 1'b1;
    end else if (wantPop && (s_reg.forceLoad || !readEnableN)) begin
      s_next.outValid = 1'b0;
    end

    // occupancy of each queue
    for (int q = 0; q < QUEUE_CNT; q++) begin
      inc = wrAccept && (s_reg.wq == QSEL_W'(q));
      dec = pop && (s_reg.rq == QSEL_W'(q));
      if (inc) begin
        s_next.wrPtr[q] = s_reg.wrPtr[q] + 3'h1;
      end
      if (dec) begin
        s_next.rdPtr[q] = s_reg.rdPtr[q] + 3'h1;
      end
      s_next.cnt[q] = s_reg.cnt[q] + {3'h0, inc} - {3'h0, dec};
    end

    // full flag tracks the selected write queue directly
    s_next.fullN = (s_next.cnt[s_next.wq] != DEPTH_CNT);

    // flags from settled counts: release one clock after the cause, assertion needs two
    s_next.afPrev = almostFull(s_reg.cnt[s_reg.wq], afOfs);
    if (!wrStrobe && (s_reg.afHold == 2'h0)) begin
      s_next.afN = !(s_reg.afPrev && s_next.afPrev);
    end
    s_next.aePrev = almostEmpty(s_reg.cnt[s_reg.rq], aeOfs);
    s_next.aeN    = !(s_reg.aePrev && s_next.aePrev);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg        <= '0;
      s_reg.fullN  <= 1'b1;
      s_reg.afN    <= 1'b1;
      s_reg.aePrev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge clk) begin
    if (wrAccept) begin
      mem[{s_reg.wq, s_reg.wrPtr[s_reg.wq]}] <= writeData;
    end
  end

  assign queueFullN    = s_reg.fullN;
  assign almostFullN   = s_reg.afN;
  assign almostFullOe  = s_reg.wrOwned;
  assign dataOut       = s_reg.dataOut;
  assign dataOe        = !outputEnableN && s_reg.rdOwned;
  assign outputReadyN  = !s_reg.outValid;
  assign almostEmptyN  = s_reg.aeN;
  assign almostEmptyOe = s_reg.rdOwned;
  assign markValid     = s_reg.markValid;
  assign markedQueue   = s_reg.markQ;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_full_block;
    !queueFullN |-> !wrAccept;
  endproperty
  a_full_block: assert property (p_full_block)
    else $error("write taken while full flag low");

  property p_switch_time;
    rdStrobe ##1 (!rdStrobe && (s_reg.rq == $past(s_reg.rq)))[*3] |=>
      s_reg.rq == $past(readQueueSelectBus, 4);
  endproperty
  a_switch_time: assert property (p_switch_time)
    else $error("read queue switch not four clocks");

  property p_hold_word;
    readEnableN && s_reg.outValid && !s_reg.forceLoad |=> $stable(dataOut) && !outputReadyN;
  endproperty
  a_hold_word: assert property (p_hold_word)
    else $error("output word changed with reads disabled");

  property p_read_empty;
    wantPop && !readEnableN && s_reg.outValid && !pop |=> outputReadyN && $stable(dataOut);
  endproperty
  a_read_empty: assert property (p_read_empty)
    else $error("output ready not raised on empty");

  property p_more_words;
    !outputReadyN && (s_reg.cnt[s_reg.rq] != '0) && !s_reg.forceLoad |=> !outputReadyN;
  endproperty
  a_more_words: assert property (p_more_words)
    else $error("output ready raised with words left");

  property p_first_word;
    wrAccept && (s_reg.wq == s_reg.rq) && (s_reg.cnt[s_reg.rq] == '0) && !s_reg.outValid
      && s_reg.rdOwned && (s_reg.rdSw == 3'h0) |=>
      outputReadyN ##1 !outputReadyN && (dataOut == $past(writeData, 2));
  endproperty
  a_first_word: assert property (p_first_word)
    else $error("first word did not fall through");

  property p_force_load;
    switchDone && s_reg.rdOwnedPend && configDone ##1 (s_reg.cnt[s_reg.rq] != '0) |=>
      !outputReadyN && (s_reg.rdPtr[s_reg.rq] != $past(s_reg.rdPtr[s_reg.rq]));
  endproperty
  a_force_load: assert property (p_force_load)
    else $error("new queue word not shown after switch");

  property p_mark_on_switch;
    $changed(markedQueue) || $rose(markValid) |-> $past(rdStrobe);
  endproperty
  a_mark_on_switch: assert property (p_mark_on_switch)
    else $error("queue marked outside a switch");

  property p_float;
    outputEnableN || !s_reg.rdOwned |-> !dataOe;
  endproperty
  a_float: assert property (p_float)
    else $error("data driven while disabled or unselected");

  property p_af_switch;
    wrStrobe |=> $stable(almostFullN) [*3];
  endproperty
  a_af_switch: assert property (p_af_switch)
    else $error("almost-full moved early after switch");

endmodule

/* mqf_port_ctrl_tb.sv */
/*
  Self-checking bench for the port controller: serial setup, fill and full,
  flag latencies, read queue switching, drain, marking, output enable
  and expansion hand-over.
  Assumes the host model above and straps held low (serial mode).
*/
module mqf_port_ctrl_tb;
  import mqf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0, resetn = 1'b0, straps = 1'b0;
  logic serialLoadEnableN, serialIn, serialEnableOutN, serialOut, configDone;
  logic writeSelectStrobe = 1'b0, writeChipSelect = 1'b1, writeEnableN = 1'b1;
  logic [QSEL_W-1:0] writeQueueSelectBus = '0, readQueueSelectBus = '0, markedQueue;
  logic [DATA_W-1:0] writeData = '0, dataOut, qBus;
  logic queueFullN, almostFullN, almostFullOe, dataOe, outputReadyN, almostEmptyN;
  logic readSelectStrobe = 1'b0, readChipSelect = 1'b1, readMarkRequest = 1'b0;
  logic readEnableN = 1'b1, outputEnableN = 1'b0, almostEmptyOe, markValid, aeWire;
  int errTotal = 0, checks = 0, cycles = 0;

  initial forever #50 clk = ~clk;

  mqf_port_ctrl u_mqf_port_ctrl (.clk(clk), .resetn(resetn),
    .programmingModeSelect(straps), .offsetSelectLow(straps),
    .offsetSelectHigh(straps), .flagDefaultSelect(straps),
    .serialLoadEnableN(serialLoadEnableN), .serialIn(serialIn),
    .serialEnableOutN(serialEnableOutN), .serialOut(serialOut), .configDone(configDone),
    .writeSelectStrobe(writeSelectStrobe), .writeQueueSelectBus(writeQueueSelectBus),
    .writeChipSelect(writeChipSelect), .writeEnableN(writeEnableN), .writeData(writeData),
    .queueFullN(queueFullN), .almostFullN(almostFullN), .almostFullOe(almostFullOe),
    .readSelectStrobe(readSelectStrobe), .readQueueSelectBus(readQueueSelectBus),
    .readChipSelect(readChipSelect), .readMarkRequest(readMarkRequest),
    .readEnableN(readEnableN), .outputEnableN(outputEnableN), .dataOut(dataOut),
    .dataOe(dataOe), .outputReadyN(outputReadyN), .almostEmptyN(almostEmptyN),
    .almostEmptyOe(almostEmptyOe), .markValid(markValid), .markedQueue(markedQueue));

  mqf_host_model u_mqf_host_model (.clk(clk), .serialLoadEnableN(serialLoadEnableN),
    .serialIn(serialIn), .serialEnableOutN(serialEnableOutN), .dataOut(dataOut),
    .dataOe(dataOe), .almostEmptyN(almostEmptyN), .almostEmptyOe(almostEmptyOe),
    .qBus(qBus), .aeWire(aeWire));

  function automatic logic [DATA_W-1:0] wd(input int i);
    return DATA_W'(36'ha50000000) + DATA_W'(i);
  endfunction

  task automatic chkB(input string nm, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chkD(input string nm, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    checks++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic selW(input logic [QSEL_W-1:0] q);
    @(negedge clk);
    writeSelectStrobe = 1'b1;
    writeQueueSelectBus = q;
    @(negedge clk);
    writeSelectStrobe = 1'b0;
  endtask

  task automatic selR(input logic [QSEL_W-1:0] q, input logic cs, input logic mk);
    @(negedge clk);
    readSelectStrobe = 1'b1;
    readQueueSelectBus = q;
    readChipSelect = cs;
    readMarkRequest = mk;
    @(negedge clk);
    readSelectStrobe = 1'b0;
    readMarkRequest = 1'b0;
  endtask

  task automatic tCfg();
    // straps are captured three clocks after reset release
    repeat (3) @(negedge clk);
    fork
      u_mqf_host_model.loadCfg(8'h32);
      begin
        repeat (3) @(negedge clk);
        chkB("serialEnableOutN", 1'b1, serialEnableOutN);
      end
    join
    u_mqf_host_model.waitChain();
    chkB("serialEnableOutN", 1'b0, serialEnableOutN);
    chkB("serialOut", 1'b1, serialOut);
    chkB("configDone", 1'b1, configDone);
    $display("test cfg done");
  endtask

  task automatic tFill();
    selW(2'h0);
    selR(2'h1, 1'b1, 1'b0);
    repeat (5) @(negedge clk);
    for (int i = 0; i <= 8; i++) begin
      @(negedge clk);
      if (i == 7) chkB("almostFullN", 1'b1, almostFullN);
      if (i == 8) chkB("almostFullN", 1'b0, almostFullN);
      writeEnableN = 1'b0;
      writeData = (i == 8) ? DATA_W'(36'hbad) : wd(i);
    end
    @(negedge clk);
    writeEnableN = 1'b1;
    chkB("queueFullN", 1'b0, queueFullN);
    chkB("almostFullOe", 1'b1, almostFullOe);
    selW(2'h2);
    @(negedge clk);
    @(negedge clk);
    chkB("almostFullN", 1'b0, almostFullN);
    @(negedge clk);
    chkB("almostFullN", 1'b1, almostFullN);
    $display("test fill done");
  endtask

  task automatic tSwitch();
    int n;
    selW(2'h0);
    selR(2'h0, 1'b1, 1'b0);
    repeat (3) begin
      @(negedge clk);
      chkB("outputReadyN", 1'b1, outputReadyN);
    end
    for (n = 0; n < 4 && outputReadyN !== 1'b0; n++) @(negedge clk);
    chkB("outputReadyN", 1'b0, outputReadyN);
    chkD("qBus", wd(0), qBus);
    repeat (3) @(negedge clk);
    chkD("qBus", wd(0), qBus);
    chkB("outputReadyN", 1'b0, outputReadyN);
    #20 outputEnableN = 1'b1;
    #1 chkB("dataOe", 1'b0, dataOe);
    outputEnableN = 1'b0;
    #1 chkB("dataOe", 1'b1, dataOe);
    $display("test switch done");
  endtask

  task automatic tDrain();
    @(negedge clk);
    readEnableN = 1'b0;
    for (int i = 1; i < 8; i++) begin
      @(negedge clk);
      chkD("qBus", wd(i), qBus);
      chkB("outputReadyN", 1'b0, outputReadyN);
      if (i == 2) chkB("almostFullN", 1'b0, almostFullN);
      if (i == 3) chkB("almostFullN", 1'b1, almostFullN);
      if (i == 5) chkB("aeWire", 1'b1, aeWire);
      if (i == 6) chkB("aeWire", 1'b0, aeWire);
    end
    @(negedge clk);
    readEnableN = 1'b1;
    chkB("outputReadyN", 1'b1, outputReadyN);
    chkD("qBus", wd(7), qBus);
    repeat (2) @(negedge clk);
    chkB("aeWire", 1'b0, aeWire);
    $display("test drain done");
  endtask

  task automatic tMark();
    @(negedge clk);
    readMarkRequest = 1'b1;
    repeat (3) @(negedge clk);
    readMarkRequest = 1'b0;
    chkB("markValid", 1'b0, markValid);
    selR(2'h2, 1'b1, 1'b1);
    repeat (5) @(negedge clk);
    chkB("markValid", 1'b1, markValid);
    chkD("markedQueue", DATA_W'(2'h2), DATA_W'(markedQueue));
    selR(2'h3, 1'b1, 1'b1);
    repeat (5) @(negedge clk);
    chkD("markedQueue", DATA_W'(2'h3), DATA_W'(markedQueue));
    $display("test mark done");
  endtask

  task automatic tFirst();
    selW(2'h3);
    @(negedge clk);
    writeEnableN = 1'b0;
    writeData = wd(9);
    @(negedge clk);
    writeEnableN = 1'b1;
    chkB("outputReadyN", 1'b1, outputReadyN);
    @(negedge clk);
    chkB("outputReadyN", 1'b0, outputReadyN);
    chkD("qBus", wd(9), qBus);
    selR(2'h0, 1'b0, 1'b0);
    repeat (6) @(negedge clk);
    chkB("dataOe", 1'b0, dataOe);
    chkB("almostEmptyOe", 1'b0, almostEmptyOe);
    $display("test first word and hand-over done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errTotal++;
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    tCfg();
    tFill();
    tSwitch();
    tDrain();
    tMark();
    tFirst();
    print_verdict();
  end
endmodule

/* mqf_serial_cfg.sv */
/*
  Serial configuration loader with daisy-chain pass-through.
  Assumes the setup straps are steady through reset and for three clocks
  after its release, and that chain pins come from logic on this clock.
*/
module mqf_serial_cfg
  import mqf_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // setup straps
  input  wire logic             programmingModeSelect,
  input  wire logic             offsetSelectLow,
  input  wire logic             offsetSelectHigh,
  input  wire logic             flagDefaultSelect,
  // serial chain
  input  wire logic             serialLoadEnableN,
  input  wire logic             serialIn,
  output logic                  serialEnableOutN,
  output logic                  serialOut,
  // configuration result
  output logic                  configDone,
  output logic [OFS_W-1:0]      almostEmptyOffset,
  output logic [OFS_W-1:0]      almostFullOffset
);
  import mqf_pkg::*;

  typedef struct packed {
    mqf_cfg_state_t        state;
    logic [3:0]            strapSync1;
    logic [3:0]            strapSync2;
    logic [1:0]            strapCnt;
    logic [CFG_BITS-1:0]   shift;
    logic [CFG_CNT_W-1:0]  bitCnt;
    logic [OFS_W-1:0]      aeOfs;
    logic [OFS_W-1:0]      afOfs;
    logic                  done;
  } mqf_cfg_reg_t;

  mqf_cfg_reg_t s_reg;
  mqf_cfg_reg_t s_next;
  logic         serialStrap;

  // strap order: mode, offset low, offset high, flag default
  assign serialStrap = !s_reg.strapSync2[3] && !s_reg.strapSync2[2] && !s_reg.strapSync2[1];

  always_comb begin
    s_next = s_reg;
    s_next.strapSync1 = {programmingModeSelect, offsetSelectLow, offsetSelectHigh,
                         flagDefaultSelect};
    s_next.strapSync2 = s_reg.strapSync1;
    unique case (s_reg.state)
      CFG_STRAP: begin
        if (s_reg.strapCnt == STRAP_CAPTURE_CYCLES) begin
          if (serialStrap) begin
            s_next.state = CFG_LOAD;
          end else begin
            s_next.aeOfs = s_reg.strapSync2[0] ? AE_DEFAULT_1 : AE_DEFAULT_0;
            s_next.afOfs = s_reg.strapSync2[0] ? AF_DEFAULT_1 : AF_DEFAULT_0;
            s_next.done  = 1'b1;
            s_next.state = CFG_DONE;
          end
        end else begin
          s_next.strapCnt = s_reg.strapCnt + 2'h1;
        end
      end
      CFG_LOAD: begin
        // flag default pin plays no part here
        if (!serialLoadEnableN) begin
          s_next.shift  = {s_reg.shift[CFG_BITS-2:0], serialIn};
          s_next.bitCnt = s_reg.bitCnt + 4'h1;
          if (s_reg.bitCnt == CFG_LAST_BIT) begin
            s_next.aeOfs = s_next.shift[AE_OFS_LSB +: OFS_W];
            s_next.afOfs = s_next.shift[AF_OFS_LSB +: OFS_W];
            s_next.done  = 1'b1;
            s_next.state = CFG_DONE;
          end
        end
      end
      CFG_DONE: begin
        s_next.done = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // chain pass-through once loaded
  assign serialEnableOutN  = s_reg.done ? serialLoadEnableN : 1'b1;
  assign serialOut         = s_reg.done ? serialIn : 1'b0;
  assign configDone        = s_reg.done;
  assign almostEmptyOffset = s_reg.aeOfs;
  assign almostFullOffset  = s_reg.afOfs;

  property p_pass_through;
    @(posedge clk) disable iff (!resetn)
    configDone |-> (serialOut == serialIn) && (serialEnableOutN == serialLoadEnableN);
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("chain not passed through after load");

  property p_no_reload;
    @(posedge clk) disable iff (!resetn)
    configDone |=> configDone && $stable(almostEmptyOffset) && $stable(almostFullOffset);
  endproperty
  a_no_reload: assert property (p_no_reload)
    else $error("configuration changed after load");

endmodule
